// ==== core/gwf_pkg.sv ====
// package: register map, field layout, reset values and timing for the gpio edge/wake-up block
`default_nettype none

package gwf_pkg;

   // ----------------------------------------
   // bus geometry
   // ----------------------------------------
   localparam int unsigned GWF_ADDR_W = 18;
   localparam int unsigned GWF_DATA_W = 32;
   localparam int unsigned GWF_IDX_W  = 16;

   // ----------------------------------------
   // register indices; byte address is four times the index
   // ----------------------------------------
   localparam logic [GWF_IDX_W-1:0] GWF_WAKE_CFG_IDX  = 16'hA02E;
   localparam logic [GWF_IDX_W-1:0] GWF_P1_FALL_IDX   = 16'hA039;
   localparam logic [GWF_IDX_W-1:0] GWF_PIN_INT_IDX   = 16'hA040;

   // ----------------------------------------
   // wake-up configuration field positions
   // ----------------------------------------
   localparam int unsigned GWF_CFG_RISE_BIT  = 7;
   localparam int unsigned GWF_CFG_FALL_BIT  = 6;
   localparam int unsigned GWF_CFG_FTIME_LSB = 4;
   localparam int unsigned GWF_CFG_SRC_LSB   = 0;

   // ----------------------------------------
   // reset values and responses
   // ----------------------------------------
   localparam logic [7:0] GWF_REG_RESET = 8'h00;
   localparam logic [1:0] GWF_RESP_OKAY   = 2'h0;
   localparam logic [1:0] GWF_RESP_SLVERR = 2'h2;

   // ----------------------------------------
   // filter timing: one unit is 1 ms, longer codes double it
   // ----------------------------------------
   localparam int unsigned GWF_CLK_PERIOD_NS   = 10;
   localparam int unsigned GWF_FILTER_UNIT_MS  = 1;
   localparam int unsigned GWF_FILTER_UNIT_CYC =
      (GWF_FILTER_UNIT_MS * 1000000 + GWF_CLK_PERIOD_NS - 1) / GWF_CLK_PERIOD_NS;
   localparam int unsigned GWF_FCNT_W          = 24;

   typedef struct packed {
      logic       rise_wake_enable;
      logic       fall_wake_enable;
      logic [1:0] filter_time_select;
      logic [3:0] wake_source_select;
   } gwf_wake_cfg_t;

   localparam gwf_wake_cfg_t GWF_WAKE_CFG_RESET = 8'h00;

endpackage : gwf_pkg

`default_nettype wire

// ==== core/gwf_noise_filter.sv ====
// module: pulse-width noise filter with edge pulses for the wake-up source
`timescale 1ns/1ns
`default_nettype none

module gwf_noise_filter
   import gwf_pkg::*;
#(
   parameter int unsigned BASE_CYCLES = gwf_pkg::GWF_FILTER_UNIT_CYC
)
(
   // clock and reset
   input  wire logic       aclk,
   input  wire logic       aresetn,
   // sample side
   input  wire logic       sample,
   input  wire logic       restart,
   input  wire logic [1:0] filter_time_select,
   // filtered side
   output logic            level,
   output logic            rise_pulse,
   output logic            fall_pulse
);

   logic [GWF_FCNT_W-1:0] cnt;
   logic [GWF_FCNT_W-1:0] next_cnt;
   logic [GWF_FCNT_W-1:0] limit;
   logic                  next_level;
   logic                  next_rise;
   logic                  next_fall;

   // ----------------------------------------
   // filter
   // ----------------------------------------
   assign limit = GWF_FCNT_W'(BASE_CYCLES) << filter_time_select;

   always_comb
   begin
      next_cnt   = '0;
      next_level = level;
      next_rise  = 1'b0;
      next_fall  = 1'b0;
      if (restart)
      begin
         // new source: adopt its level silently, no false edge
         next_level = sample;
      end
      else if (sample != level)
      begin
         // a mismatch shorter than limit never reaches the output
         if (cnt + 1'b1 >= limit)
         begin
            next_level = sample;
            next_rise  = sample;
            next_fall  = ~sample;
         end
         else
         begin
            next_cnt = cnt + 1'b1;
         end
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         cnt        <= '0;
         level      <= 1'b0;
         rise_pulse <= 1'b0;
         fall_pulse <= 1'b0;
      end
      else
      begin
         cnt        <= next_cnt;
         level      <= next_level;
         rise_pulse <= next_rise;
         fall_pulse <= next_fall;
      end
   end

   property p_filter_min_width;
      @(posedge aclk) disable iff (!aresetn)
      (rise_pulse || fall_pulse) |-> ($past(cnt) + 1'b1 >= $past(limit));
   endproperty
   a_filter_min_width : assert property (p_filter_min_width) else $error("filter passed a short pulse");

endmodule : gwf_noise_filter // gwf_noise_filter

`default_nettype wire

// ==== core/gwf_top.sv ====
// module: port-1 falling-edge latches and filtered gpio wake-up detector, AXI4-Lite slave
//
// Chosen here: register access over AXI4-Lite.
`timescale 1ns/1ns
`default_nettype none

module gwf_top
   import gwf_pkg::*;
#(
   parameter int unsigned FILTER_BASE_CYCLES = gwf_pkg::GWF_FILTER_UNIT_CYC
)
(
   // clock and reset
   input  wire logic                  aclk,
   input  wire logic                  aresetn,
   // axi4-lite write address and data
   input  wire logic [GWF_ADDR_W-1:0] awaddr,
   input  wire logic                  awvalid,
   output logic                       awready,
   input  wire logic [GWF_DATA_W-1:0] wdata,
   input  wire logic [3:0]            wstrb,
   input  wire logic                  wvalid,
   output logic                       wready,
   // axi4-lite write response
   output logic [1:0]                 bresp,
   output logic                       bvalid,
   input  wire logic                  bready,
   // axi4-lite read
   input  wire logic [GWF_ADDR_W-1:0] araddr,
   input  wire logic                  arvalid,
   output logic                       arready,
   output logic [GWF_DATA_W-1:0]      rdata,
   output logic [1:0]                 rresp,
   output logic                       rvalid,
   input  wire logic                  rready,
   // gpio pins, asynchronous
   input  wire logic [7:0]            port0_pin,
   input  wire logic [7:0]            port1_pin,
   // power control and interrupt
   output logic                       pin_irq,
   output logic                       wake_request
);
   import gwf_pkg::*;

   // ----------------------------------------
   // pin synchronisers
   // ----------------------------------------
   logic [15:0] sync1;
   logic [15:0] sync2;
   logic [15:0] sync3;
   logic [15:0] stable;
   logic [15:0] next_stable;

   // a bit changes only once the second and third stages agree
   assign next_stable = (sync2 & sync3) | (stable & (sync2 ^ sync3));

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         sync1  <= '0;
         sync2  <= '0;
         sync3  <= '0;
         stable <= '0;
      end
      else
      begin
         sync1  <= {port1_pin, port0_pin};
         sync2  <= sync1;
         sync3  <= sync2;
         stable <= next_stable;
      end
   end

   // ----------------------------------------
   // axi4-lite slave
   // ----------------------------------------
   logic                  aw_held;
   logic                  w_held;
   logic [GWF_IDX_W-1:0]  aw_idx;
   logic [7:0]            w_byte;
   logic                  w_lane0;
   logic                  next_aw_held;
   logic                  next_w_held;
   logic [GWF_IDX_W-1:0]  next_aw_idx;
   logic [7:0]            next_w_byte;
   logic                  next_w_lane0;
   logic                  next_awready;
   logic                  next_wready;
   logic                  next_bvalid;
   logic [1:0]            next_bresp;
   logic                  next_arready;
   logic                  next_rvalid;
   logic [1:0]            next_rresp;
   logic [GWF_DATA_W-1:0] next_rdata;
   logic                  do_write;
   logic                  wr_cfg;
   logic                  wr_fall;
   logic                  wr_pint;
   logic                  rd_take;
   logic [GWF_IDX_W-1:0]  ar_idx;

   // state held for software; port1_fall_detect_enable and the two wake enable bits are not read back
   gwf_wake_cfg_t wake_cfg;
   logic          rise_wake_flag;
   logic          fall_wake_flag;
   logic [7:0]    port1_fall_detect_enable;
   logic [7:0]    port1_fall_status;
   logic [7:0]    pin_interrupt_enable;

   assign do_write = aw_held && w_held && !bvalid;
   assign wr_cfg   = do_write && w_lane0 && (aw_idx == GWF_WAKE_CFG_IDX);
   assign wr_fall  = do_write && w_lane0 && (aw_idx == GWF_P1_FALL_IDX);
   assign wr_pint  = do_write && w_lane0 && (aw_idx == GWF_PIN_INT_IDX);
   assign rd_take  = arvalid && arready;
   assign ar_idx   = araddr[GWF_ADDR_W-1:2];

   always_comb
   begin
      next_aw_held = aw_held;
      next_w_held  = w_held;
      next_aw_idx  = aw_idx;
      next_w_byte  = w_byte;
      next_w_lane0 = w_lane0;
      next_bvalid  = bvalid;
      next_bresp   = bresp;
      if (awvalid && awready)
      begin
         next_aw_held = 1'b1;
         next_aw_idx  = awaddr[GWF_ADDR_W-1:2];
      end
      if (wvalid && wready)
      begin
         next_w_held  = 1'b1;
         next_w_byte  = wdata[7:0];
         next_w_lane0 = wstrb[0];
      end
      if (do_write)
      begin
         next_aw_held = 1'b0;
         next_w_held  = 1'b0;
         next_bvalid  = 1'b1;
         next_bresp   = ((aw_idx == GWF_WAKE_CFG_IDX) || (aw_idx == GWF_P1_FALL_IDX) ||
                         (aw_idx == GWF_PIN_INT_IDX)) ? GWF_RESP_OKAY : GWF_RESP_SLVERR;
      end
      else if (bvalid && bready)
      begin
         next_bvalid = 1'b0;
      end
      // one write in flight: hold both channels off until the response drains
      next_awready = !next_aw_held && !next_bvalid;
      next_wready  = !next_w_held && !next_bvalid;
   end

   always_comb
   begin
      next_rvalid  = rvalid;
      next_rdata   = rdata;
      next_rresp   = rresp;
      if (rd_take)
      begin
         next_rvalid = 1'b1;
         next_rresp  = GWF_RESP_OKAY;
         unique case (ar_idx)
            GWF_WAKE_CFG_IDX:
               next_rdata = {24'h000000, rise_wake_flag, fall_wake_flag,
                             wake_cfg.filter_time_select, wake_cfg.wake_source_select};
            GWF_P1_FALL_IDX:
               next_rdata = {24'h000000, port1_fall_status};
            GWF_PIN_INT_IDX:
               next_rdata = {24'h000000, pin_interrupt_enable};
            default:
            begin
               next_rdata = 32'h00000000;
               next_rresp = GWF_RESP_SLVERR;
            end
         endcase
      end
      else if (rvalid && rready)
      begin
         next_rvalid = 1'b0;
      end
      next_arready = !next_rvalid;
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         aw_held <= 1'b0;
         w_held  <= 1'b0;
         aw_idx  <= '0;
         w_byte  <= 8'h00;
         w_lane0 <= 1'b0;
         awready <= 1'b0;
         wready  <= 1'b0;
         bvalid  <= 1'b0;
         bresp   <= GWF_RESP_OKAY;
         arready <= 1'b0;
         rvalid  <= 1'b0;
         rresp   <= GWF_RESP_OKAY;
         rdata   <= 32'h00000000;
      end
      else
      begin
         aw_held <= next_aw_held;
         w_held  <= next_w_held;
         aw_idx  <= next_aw_idx;
         w_byte  <= next_w_byte;
         w_lane0 <= next_w_lane0;
         awready <= next_awready;
         wready  <= next_wready;
         bvalid  <= next_bvalid;
         bresp   <= next_bresp;
         arready <= next_arready;
         rvalid  <= next_rvalid;
         rresp   <= next_rresp;
         rdata   <= next_rdata;
      end
   end

   // ----------------------------------------
   // port-1 falling-edge latches
   // ----------------------------------------
   logic [7:0] fall_evt;
   logic [7:0] fall_set;
   logic [7:0] fall_clr;
   logic [7:0] next_fall_en;
   logic [7:0] next_fall_status;
   logic [7:0] next_pint_en;
   logic       next_pin_irq;

   assign fall_evt = stable[15:8] & ~next_stable[15:8];
   assign fall_set = fall_evt & port1_fall_detect_enable;
   assign fall_clr = wr_fall ? ~w_byte : 8'h00;

   always_comb
   begin
      next_fall_en     = wr_fall ? w_byte : port1_fall_detect_enable;
      // a new edge in the clearing cycle survives
      next_fall_status = (port1_fall_status & ~fall_clr) | fall_set;
      next_pint_en     = wr_pint ? w_byte : pin_interrupt_enable;
      next_pin_irq     = |(port1_fall_status & pin_interrupt_enable);
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         port1_fall_detect_enable <= GWF_REG_RESET;
         port1_fall_status        <= GWF_REG_RESET;
         pin_interrupt_enable     <= GWF_REG_RESET;
         pin_irq                  <= 1'b0;
      end
      else
      begin
         port1_fall_detect_enable <= next_fall_en;
         port1_fall_status        <= next_fall_status;
         pin_interrupt_enable     <= next_pint_en;
         pin_irq                  <= next_pin_irq;
      end
   end

   // ----------------------------------------
   // filtered wake-up detector
   // ----------------------------------------
   logic          wake_sample;
   logic          src_changed;
   logic          filt_rise;
   logic          filt_fall;
   gwf_wake_cfg_t next_wake_cfg;
   logic          next_rise_flag;
   logic          next_fall_flag;
   logic          next_wake_request;

   // follow the source being written, so a restart loads the new pin's level, not the old one
   assign wake_sample = stable[next_wake_cfg.wake_source_select];
   assign src_changed = wr_cfg && (w_byte[3:0] != wake_cfg.wake_source_select);

   // limitation: aclk must stay running in sleep for the filter to time out
   gwf_noise_filter #(
      .BASE_CYCLES        (FILTER_BASE_CYCLES)
   ) u_filter (
      .aclk               (aclk),
      .aresetn            (aresetn),
      .sample             (wake_sample),
      .restart            (src_changed),
      .filter_time_select (wake_cfg.filter_time_select),
      .level              (),
      .rise_pulse         (filt_rise),
      .fall_pulse         (filt_fall)
   );

   always_comb
   begin
      next_wake_cfg  = wr_cfg ? gwf_wake_cfg_t'(w_byte) : wake_cfg;
      next_rise_flag = rise_wake_flag;
      next_fall_flag = fall_wake_flag;
      if (wr_cfg && !w_byte[GWF_CFG_RISE_BIT])
      begin
         next_rise_flag = 1'b0;
      end
      if (wr_cfg && !w_byte[GWF_CFG_FALL_BIT])
      begin
         next_fall_flag = 1'b0;
      end
      // set wins over the clear
      if (filt_rise && wake_cfg.rise_wake_enable)
      begin
         next_rise_flag = 1'b1;
      end
      if (filt_fall && wake_cfg.fall_wake_enable)
      begin
         next_fall_flag = 1'b1;
      end
      next_wake_request = rise_wake_flag || fall_wake_flag || next_pin_irq;
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         wake_cfg       <= GWF_WAKE_CFG_RESET;
         rise_wake_flag <= 1'b0;
         fall_wake_flag <= 1'b0;
         wake_request   <= 1'b0;
      end
      else
      begin
         wake_cfg       <= next_wake_cfg;
         rise_wake_flag <= next_rise_flag;
         fall_wake_flag <= next_fall_flag;
         wake_request   <= next_wake_request;
      end
   end

   // ----------------------------------------
   // checks
   // ----------------------------------------
   sequence s_cfg_read;
      arvalid && arready && (ar_idx == GWF_WAKE_CFG_IDX);
   endsequence

   property p_fall_set;
      @(posedge aclk) disable iff (!aresetn)
      (fall_set != 8'h00) |=> ((port1_fall_status & $past(fall_set)) == $past(fall_set));
   endproperty
   a_fall_set : assert property (p_fall_set) else $error("falling edge did not set status");

   property p_fall_hold;
      @(posedge aclk) disable iff (!aresetn)
      !wr_fall |=> ((port1_fall_status & $past(port1_fall_status)) == $past(port1_fall_status));
   endproperty
   a_fall_hold : assert property (p_fall_hold) else $error("status dropped without clear");

   property p_irq;
      @(posedge aclk) disable iff (!aresetn)
      ((port1_fall_status & pin_interrupt_enable) != 8'h00) |=> pin_irq;
   endproperty
   a_irq : assert property (p_irq) else $error("enabled status gave no interrupt");

   property p_fall_read;
      @(posedge aclk) disable iff (!aresetn)
      (rd_take && (ar_idx == GWF_P1_FALL_IDX)) |=> (rvalid && rdata[7:0] == $past(port1_fall_status));
   endproperty
   a_fall_read : assert property (p_fall_read) else $error("read did not return status");

   property p_wake_from_edge;
      @(posedge aclk) disable iff (!aresetn)
      pin_irq |-> wake_request;
   endproperty
   a_wake_from_edge : assert property (p_wake_from_edge) else $error("edge interrupt without wake");

   property p_rise_flag;
      @(posedge aclk) disable iff (!aresetn)
      (filt_rise && wake_cfg.rise_wake_enable) |=> rise_wake_flag ##1 wake_request;
   endproperty
   a_rise_flag : assert property (p_rise_flag) else $error("rise trigger lost");

   property p_fall_flag;
      @(posedge aclk) disable iff (!aresetn)
      (filt_fall && wake_cfg.fall_wake_enable) |=> fall_wake_flag ##1 wake_request;
   endproperty
   a_fall_flag : assert property (p_fall_flag) else $error("fall trigger lost");

   property p_cfg_read;
      @(posedge aclk) disable iff (!aresetn)
      s_cfg_read |=> (rdata[7:6] == {$past(rise_wake_flag), $past(fall_wake_flag)});
   endproperty
   a_cfg_read : assert property (p_cfg_read) else $error("config read lost flags");

   property p_rise_clear;
      @(posedge aclk) disable iff (!aresetn)
      (wr_cfg && !w_byte[GWF_CFG_RISE_BIT] && !filt_rise) |=> !rise_wake_flag;
   endproperty
   a_rise_clear : assert property (p_rise_clear) else $error("rise flag not cleared");

endmodule : gwf_top // gwf_top

`default_nettype wire

// ==== tb/gwf_pin_model.sv ====
// partner model: external levels on the port 0 and port 1 input pins
`timescale 1ns/1ns
`default_nettype none

module gwf_pin_model
(
   // clock
   input  wire logic       aclk,
   // pin levels
   output logic [7:0]      port0_pin,
   output logic [7:0]      port1_pin
);
   // port 1 idles high so a first event on it is a falling edge
   initial
   begin
      port0_pin = 8'h00;
      port1_pin = 8'hFF;
   end

   task automatic set_pin(input logic p, input logic [2:0] i, input logic v);
      @(posedge aclk);
      if (p)
         port1_pin[i] <= v;
      else
         port0_pin[i] <= v;
   endtask

   // level v for w cycles, then back
   task automatic pulse(input logic p, input logic [2:0] i, input logic v, input int w);
      set_pin(p, i, v);
      repeat (w - 1) @(posedge aclk);
      set_pin(p, i, !v);
   endtask
endmodule // gwf_pin_model

`default_nettype wire

// ==== tb/gwf_top_tb.sv ====
// testbench: register access, edge latches and filtered wake-up
`timescale 1ns/1ns
`default_nettype none

module gwf_top_tb;
   import gwf_pkg::*;
   // short filter unit keeps the 8x code cheap
   localparam int unsigned BASE  = 8;
   localparam logic [17:0] A_CFG = {GWF_WAKE_CFG_IDX, 2'b00};
   localparam logic [17:0] A_P1F = {GWF_P1_FALL_IDX, 2'b00};
   localparam logic [17:0] A_PIE = {GWF_PIN_INT_IDX, 2'b00};
   localparam logic [17:0] A_BAD = 18'h00004;
   logic        aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
   logic        arvalid, arready, rvalid, rready, pin_irq, wake_request;
   logic [17:0] awaddr, araddr;
   logic [31:0] wdata, rdata;
   logic [3:0]  wstrb;
   logic [1:0]  bresp, rresp;
   logic [7:0]  port0_pin, port1_pin;
   int          num_errors = 0;
   int          n_compared = 0;

   gwf_top #(.FILTER_BASE_CYCLES(BASE)) dut
   (
      .aclk(aclk), .aresetn(aresetn),
      .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
      .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
      .bresp(bresp), .bvalid(bvalid), .bready(bready),
      .araddr(araddr), .arvalid(arvalid), .arready(arready),
      .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
      .port0_pin(port0_pin), .port1_pin(port1_pin),
      .pin_irq(pin_irq), .wake_request(wake_request)
   );

   gwf_pin_model pins (.aclk(aclk), .port0_pin(port0_pin), .port1_pin(port1_pin));

   initial
   begin
      aclk = 1'b0;
      forever #5 aclk = ~aclk;
   end

   // ----------------------------------------
   // helpers
   // ----------------------------------------
   task automatic stop_test;
      $display("compared %0d, errors %0d", n_compared, num_errors);
      if (num_errors == 0 && n_compared > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp)
      begin
         num_errors++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic hold(input int n);
      repeat (n) @(posedge aclk);
   endtask

   task automatic wr(input logic [17:0] a, input logic [7:0] d, input logic [1:0] er = GWF_RESP_OKAY);
      logic aw_done;
      logic w_done;
      aw_done = 1'b0;
      w_done = 1'b0;
      awaddr <= a;
      wdata <= {24'h0, d};
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      while (!(aw_done && w_done))
      begin
         @(posedge aclk);
         aw_done = aw_done | awready;
         w_done = w_done | wready;
         awvalid <= !aw_done;
         wvalid <= !w_done;
      end
      do @(posedge aclk); while (bvalid !== 1'b1);
      bready <= 1'b0;
      chk(bresp, er);
   endtask

   task automatic rd(input logic [17:0] a, input logic [7:0] e, input logic [1:0] er = GWF_RESP_OKAY);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do @(posedge aclk); while (arready !== 1'b1);
      arvalid <= 1'b0;
      do @(posedge aclk); while (rvalid !== 1'b1);
      rready <= 1'b0;
      chk(rdata, {24'h0, e});
      chk(rresp, er);
   endtask

   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   task automatic t_reset;
      rd(A_CFG, 8'h00);
      rd(A_P1F, 8'h00);
      rd(A_PIE, 8'h00);
      wr(A_BAD, 8'hFF, GWF_RESP_SLVERR);
      rd(A_BAD, 8'h00, GWF_RESP_SLVERR);
   endtask

   task automatic t_fall;
      wr(A_P1F, 8'h28);
      pins.pulse(1'b1, 3'd3, 1'b0, 4);
      pins.pulse(1'b1, 3'd4, 1'b0, 4);
      hold(8);
      rd(A_P1F, 8'h08);
      chk(pin_irq, 1'b0);
      wr(A_PIE, 8'h08);
      hold(3);
      chk(pin_irq, 1'b1);
      chk(wake_request, 1'b1);
      wr(A_PIE, 8'h00);
      hold(3);
      chk(pin_irq, 1'b0);
      rd(A_P1F, 8'h08);
      wr(A_P1F, 8'h20);
      rd(A_P1F, 8'h00);
      pins.pulse(1'b1, 3'd5, 1'b0, 4);
      hold(8);
      rd(A_P1F, 8'h20);
      wr(A_P1F, 8'h00);
      rd(A_P1F, 8'h00);
      hold(3);
      chk(wake_request, 1'b0);
   endtask

   task automatic t_wake;
      wr(A_CFG, 8'hC2);
      pins.pulse(1'b0, 3'd2, 1'b1, BASE - 2);
      hold(12);
      rd(A_CFG, 8'h02);
      pins.pulse(1'b0, 3'd3, 1'b1, BASE + 8);
      hold(12);
      rd(A_CFG, 8'h02);
      pins.set_pin(1'b0, 3'd2, 1'b1);
      hold(BASE + 8);
      rd(A_CFG, 8'h82);
      chk(wake_request, 1'b1);
      pins.set_pin(1'b0, 3'd2, 1'b0);
      hold(BASE + 8);
      rd(A_CFG, 8'hC2);
      wr(A_CFG, 8'h02);
      rd(A_CFG, 8'h02);
      hold(2);
      chk(wake_request, 1'b0);
   endtask

   // rise only on port 1 pin 7; pulse two short of the window is dropped
   task automatic t_filter;
      int n;
      for (int c = 0; c < 4; c++)
      begin
         n = BASE << c;
         wr(A_CFG, {2'b10, c[1:0], 4'hF});
         pins.set_pin(1'b1, 3'd7, 1'b0);
         hold(n + 8);
         pins.pulse(1'b1, 3'd7, 1'b1, n - 2);
         hold(n + 8);
         rd(A_CFG, {2'b00, c[1:0], 4'hF});
         pins.set_pin(1'b1, 3'd7, 1'b1);
         hold(n + 8);
         rd(A_CFG, {2'b10, c[1:0], 4'hF});
         wr(A_CFG, {2'b00, c[1:0], 4'hF});
      end
   endtask

   initial
   begin
      #200000;
      num_errors++;
      stop_test();
   end

   initial
   begin
      {aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
      {awaddr, araddr, wdata} = '0;
      wstrb = 4'hF;
      hold(5);
      aresetn <= 1'b1;
      hold(4);
      t_reset();
      t_fall();
      t_wake();
      t_filter();
      stop_test();
   end
endmodule // gwf_top_tb

`default_nettype wire
